// >>> hw/pfsr_regs.svh
// Register indices, addresses, field positions and reset values for fault status and recovery
`ifndef PFSR_REGS_SVH
`define PFSR_REGS_SVH

// Register indices; byte address is four times the index
`define PFSR_IDX_MASK 24'hffe384
`define PFSR_IDX_STAT 24'hffe385
`define PFSR_IDX_SAMPLE 24'hffe386
`define PFSR_IDX_CTRL 24'hffe388

`define PFSR_ADDR_MASK ({6'h00, `PFSR_IDX_MASK, 2'h0})
`define PFSR_ADDR_STAT ({6'h00, `PFSR_IDX_STAT, 2'h0})
`define PFSR_ADDR_SAMPLE ({6'h00, `PFSR_IDX_SAMPLE, 2'h0})
`define PFSR_ADDR_CTRL ({6'h00, `PFSR_IDX_CTRL, 2'h0})

// Status register bits
`define PFSR_ST_FAULT_PIN 0
`define PFSR_ST_COMP_TRIP 1
`define PFSR_ST_SECOND 2
`define PFSR_ST_DEBUG 5
`define PFSR_ST_RELOAD 7

// Control register bits
`define PFSR_CT_PIN_RST 0
`define PFSR_CT_PIN_IRQ 1
`define PFSR_CT_CA_RST 2
`define PFSR_CT_CA_IRQ 3
`define PFSR_CT_CB_RST 4
`define PFSR_CT_CB_IRQ 5
`define PFSR_CT_DBG_RST 6

// Mask register bits
`define PFSR_MK_PIN 0
`define PFSR_MK_COMP 1
`define PFSR_MK_SECOND 2
`define PFSR_MK_DEBUG 5

// Sample register bits
`define PFSR_SM_FAULT_PIN 6

// Reset values
`define PFSR_RST_CTRL 7'h00
`define PFSR_RST_MASK 4'h0
`define PFSR_RST_FLAGS 5'h00

// Synchroniser width: four fault inputs and six output pins
`define PFSR_SYNC_W 10

`endif

// >>> hw/pfsr_pkg.sv
// Types shared by the fault status and recovery block
package pfsr_pkg;

  typedef struct packed {
    logic [31:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } pfsr_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } pfsr_apb_rsp_t;

  typedef struct packed {
    logic fault_pin;
    logic comp_a;
    logic comp_b;
    logic second_fault;
    logic debug;
  } pfsr_src_t;

  typedef struct packed {
    logic comp_b;
    logic comp_a;
    logic fault_pin;
  } pfsr_irq_t;

  typedef struct packed {
    logic reload_seen;
    logic debug_entry_seen;
    logic second_fault_seen;
    logic comparator_trip_seen;
    logic fault_pin_seen;
  } pfsr_flags_t;

  typedef struct packed {
    logic debug_restart_sel;
    logic comp_b_irq_en;
    logic comp_b_restart_sel;
    logic comp_a_irq_en;
    logic comp_a_restart_sel;
    logic fault_pin_irq_en;
    logic fault_pin_restart_sel;
  } pfsr_ctrl_t;

  typedef struct packed {
    logic debug_mask;
    logic second_fault_mask;
    logic comp_mask;
    logic fault_pin_mask;
  } pfsr_mask_t;

  typedef enum logic [1:0] {
    PFSR_ST_RUN,
    PFSR_ST_HALT,
    PFSR_ST_ARMED
  } pfsr_fsm_t;

  typedef struct packed {
    pfsr_fsm_t fsm;
    pfsr_flags_t flags;
    pfsr_ctrl_t ctrl;
    pfsr_mask_t mask;
    logic mask_locked;
    pfsr_src_t cause;
    pfsr_irq_t irq_prev;
    pfsr_irq_t irq;
    logic force_off;
    logic [31:0] prdata;
    logic pslverr;
  } pfsr_state_t;

endpackage : pfsr_pkg

// >>> hw/pfsr_sync.sv
// Two-flop synchroniser bank for the fault inputs and sampled output pins
`timescale 1ns/100ps
`include "pfsr_regs.svh"

module pfsr_sync (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic [`PFSR_SYNC_W-1:0] i_async,
  output logic [`PFSR_SYNC_W-1:0] o_sync
);

  genvar g;
  generate
    for (g = 0; g < `PFSR_SYNC_W; g = g + 1) begin : g_bit
      logic meta_r;
      logic sync_r;
      // First stage feeds only the second stage
      always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
          meta_r <= 1'h0;
          sync_r <= 1'h0;
        end else begin
          meta_r <= i_async[g];
          sync_r <= meta_r;
        end
      end
      assign o_sync[g] = sync_r;
    end
  endgenerate

endmodule : pfsr_sync

// >>> hw/pfsr_top.sv
// Fault status flags, fault mask, recovery control and pin sampling with an APB slave
`timescale 1ns/100ps
`include "pfsr_regs.svh"

module pfsr_top (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire pfsr_pkg::pfsr_apb_req_t i_apb,
  output pfsr_pkg::pfsr_apb_rsp_t o_apb,
  input wire logic i_fault_pin,
  input wire logic i_comp_a,
  input wire logic i_comp_b,
  input wire logic i_second_fault,
  input wire logic i_debug_mode,
  input wire logic i_reload,
  input wire logic i_period_start,
  input wire logic [5:0] i_pwm_pins,
  output logic o_force_off,
  output pfsr_pkg::pfsr_irq_t o_irq_req
);

  import pfsr_pkg::*;

  logic [`PFSR_SYNC_W-1:0] sync_in;
  logic [`PFSR_SYNC_W-1:0] sync_out;
  pfsr_state_t s_r;
  pfsr_state_t s_nxt;
  pfsr_src_t src;
  pfsr_src_t act;
  logic [5:0] pin_level_sample;
  logic any_act;
  logic cause_sw;
  logic cause_dbg_auto;
  logic flags_clear;
  logic setup;
  logic access;
  logic wr_stat;
  logic wr_ctrl;
  logic wr_mask;
  logic addr_hit;
  logic [7:0] stat_rd;
  logic [7:0] ctrl_rd;
  logic [7:0] mask_rd;
  logic [7:0] sample_rd;
  logic [7:0] rd_byte;
  logic [2:0] irq_src;
  logic [2:0] irq_en;
  logic [2:0] irq_rise;
  genvar g;

  // Pins and comparators are asynchronous to the system clock
  // Bits 3:0 carry the fault sources and bits 9:4 the six output pins
  assign sync_in = {i_pwm_pins, i_second_fault, i_comp_b, i_comp_a, i_fault_pin};

  pfsr_sync u_sync (
    .i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn),
    .i_async(sync_in),
    .o_sync(sync_out)
  );

  // Debug state comes from CPU logic on the same clock
  always_comb begin
    src.fault_pin = sync_out[0];
    src.comp_a = sync_out[1];
    src.comp_b = sync_out[2];
    src.second_fault = sync_out[3];
    src.debug = i_debug_mode;
    pin_level_sample = sync_out[9:4];
  end

  always_comb begin
    act.fault_pin = src.fault_pin & ~s_r.mask.fault_pin_mask;
    act.comp_a = src.comp_a & ~s_r.mask.comp_mask;
    act.second_fault = src.second_fault & ~s_r.mask.second_fault_mask;
    act.debug = src.debug & ~s_r.mask.debug_mask;
    // Comparator b has no mask bit, so it always counts
    act.comp_b = src.comp_b;
    any_act = |act;
  end

  // Bus decode; write takes effect on the access edge
  assign setup = i_apb.psel & ~i_apb.penable;
  assign access = i_apb.psel & i_apb.penable;
  assign wr_stat = access & i_apb.pwrite & (i_apb.paddr == `PFSR_ADDR_STAT);
  assign wr_ctrl = access & i_apb.pwrite & (i_apb.paddr == `PFSR_ADDR_CTRL);
  assign wr_mask = access & i_apb.pwrite & (i_apb.paddr == `PFSR_ADDR_MASK);
  assign addr_hit = (i_apb.paddr == `PFSR_ADDR_STAT) | (i_apb.paddr == `PFSR_ADDR_CTRL) |
                    (i_apb.paddr == `PFSR_ADDR_MASK) | (i_apb.paddr == `PFSR_ADDR_SAMPLE);

  always_comb begin
    stat_rd = 8'h00;
    stat_rd[`PFSR_ST_RELOAD] = s_r.flags.reload_seen;
    stat_rd[`PFSR_ST_DEBUG] = s_r.flags.debug_entry_seen;
    stat_rd[`PFSR_ST_SECOND] = s_r.flags.second_fault_seen;
    stat_rd[`PFSR_ST_COMP_TRIP] = s_r.flags.comparator_trip_seen;
    stat_rd[`PFSR_ST_FAULT_PIN] = s_r.flags.fault_pin_seen;
  end

  always_comb begin
    ctrl_rd = {1'h0, s_r.ctrl};
    mask_rd = 8'h00;
    mask_rd[`PFSR_MK_DEBUG] = s_r.mask.debug_mask;
    mask_rd[`PFSR_MK_SECOND] = s_r.mask.second_fault_mask;
    mask_rd[`PFSR_MK_COMP] = s_r.mask.comp_mask;
    mask_rd[`PFSR_MK_PIN] = s_r.mask.fault_pin_mask;
  end

  // sampled pin levels
  // Levels lag the pins by two clocks; software never sees a raw pin
  always_comb begin
    sample_rd = {2'h0, pin_level_sample};
    sample_rd[`PFSR_SM_FAULT_PIN] = src.fault_pin;
  end

  // Read multiplexer; an unmapped address reads zero and raises the error bit
  always_comb begin
    rd_byte = 8'h00;
    unique case (1'b1)
      i_apb.paddr == `PFSR_ADDR_STAT: rd_byte = stat_rd;
      i_apb.paddr == `PFSR_ADDR_CTRL: rd_byte = ctrl_rd;
      i_apb.paddr == `PFSR_ADDR_MASK: rd_byte = mask_rd;
      i_apb.paddr == `PFSR_ADDR_SAMPLE: rd_byte = sample_rd;
      default: rd_byte = 8'h00;
    endcase
  end

  // Edge detect per interrupt source; the previous level resets low, the idle pin level
  assign irq_src = {src.comp_b, src.comp_a, src.fault_pin};
  assign irq_en = {s_r.ctrl.comp_b_irq_en, s_r.ctrl.comp_a_irq_en, s_r.ctrl.fault_pin_irq_en};
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_irq
      assign irq_rise[g] = irq_src[g] & ~s_r.irq_prev[g] & irq_en[g];
    end
  endgenerate

  // Recovery terms
  // One cause in software mode puts the whole episode in software mode
  // The second fault source has no restart bit and so recovers on its own unless another cause in the episode selects software mode
  always_comb begin
    cause_sw = (s_r.cause.fault_pin & s_r.ctrl.fault_pin_restart_sel) |
               (s_r.cause.comp_a & s_r.ctrl.comp_a_restart_sel) |
               (s_r.cause.comp_b & s_r.ctrl.comp_b_restart_sel) |
               (s_r.cause.debug & s_r.ctrl.debug_restart_sel);
    cause_dbg_auto = s_r.cause.debug & ~s_r.ctrl.debug_restart_sel;
    flags_clear = ~(s_r.flags.debug_entry_seen | s_r.flags.second_fault_seen |
                    s_r.flags.comparator_trip_seen | s_r.flags.fault_pin_seen);
  end

  always_comb begin
    s_nxt = s_r;

    if (wr_stat) begin
      if (i_apb.pwdata[`PFSR_ST_RELOAD]) begin
        s_nxt.flags.reload_seen = 1'h0;
      end
      if (i_apb.pwdata[`PFSR_ST_DEBUG] && !src.debug) begin
        s_nxt.flags.debug_entry_seen = 1'h0;
      end
      if (i_apb.pwdata[`PFSR_ST_SECOND] && !src.second_fault) begin
        s_nxt.flags.second_fault_seen = 1'h0;
      end
      if (i_apb.pwdata[`PFSR_ST_COMP_TRIP] && !src.comp_a) begin
        s_nxt.flags.comparator_trip_seen = 1'h0;
      end
      if (i_apb.pwdata[`PFSR_ST_FAULT_PIN] && !src.fault_pin) begin
        s_nxt.flags.fault_pin_seen = 1'h0;
      end
    end

    // Sets come after clears so a coincident event is never lost
    // reload flag
    if (i_reload) begin
      s_nxt.flags.reload_seen = 1'h1;
    end
    if (act.debug) begin
      s_nxt.flags.debug_entry_seen = 1'h1;
    end
    if (act.second_fault) begin
      s_nxt.flags.second_fault_seen = 1'h1;
    end
    if (act.comp_a) begin
      s_nxt.flags.comparator_trip_seen = 1'h1;
    end
    if (act.fault_pin) begin
      s_nxt.flags.fault_pin_seen = 1'h1;
    end
    // masked sources leave flags alone, see act above

    if (wr_ctrl) begin
      s_nxt.ctrl.debug_restart_sel = i_apb.pwdata[`PFSR_CT_DBG_RST];
      s_nxt.ctrl.comp_b_irq_en = i_apb.pwdata[`PFSR_CT_CB_IRQ];
      s_nxt.ctrl.comp_b_restart_sel = i_apb.pwdata[`PFSR_CT_CB_RST];
      s_nxt.ctrl.comp_a_irq_en = i_apb.pwdata[`PFSR_CT_CA_IRQ];
      s_nxt.ctrl.comp_a_restart_sel = i_apb.pwdata[`PFSR_CT_CA_RST];
      s_nxt.ctrl.fault_pin_irq_en = i_apb.pwdata[`PFSR_CT_PIN_IRQ];
      s_nxt.ctrl.fault_pin_restart_sel = i_apb.pwdata[`PFSR_CT_PIN_RST];
    end

    // Mask is write-once after reset so a runaway program cannot unmask faults
    if (wr_mask && !s_r.mask_locked) begin
      s_nxt.mask.debug_mask = i_apb.pwdata[`PFSR_MK_DEBUG];
      s_nxt.mask.second_fault_mask = i_apb.pwdata[`PFSR_MK_SECOND];
      s_nxt.mask.comp_mask = i_apb.pwdata[`PFSR_MK_COMP];
      s_nxt.mask.fault_pin_mask = i_apb.pwdata[`PFSR_MK_PIN];
      s_nxt.mask_locked = 1'h1;
    end

    // Interrupt requests are one-cycle pulses on the rising edge of the source
    s_nxt.irq_prev = pfsr_irq_t'(irq_src);
    s_nxt.irq = pfsr_irq_t'(irq_rise);

    unique case (s_r.fsm)
      PFSR_ST_RUN: begin
        if (any_act) begin
          s_nxt.fsm = PFSR_ST_HALT;
          s_nxt.cause = act;
        end
      end
      PFSR_ST_HALT: begin
        s_nxt.cause = s_r.cause | act;
        if (!any_act) begin
          if (cause_sw) begin
            if (flags_clear) begin
              s_nxt.fsm = PFSR_ST_ARMED;
            end
          end else if (cause_dbg_auto) begin
            if (i_period_start) begin
              s_nxt.fsm = PFSR_ST_RUN;
            end
          end else begin
            s_nxt.fsm = PFSR_ST_RUN;
          end
        end
      end
      PFSR_ST_ARMED: begin
        // A new fault or a flag set again while armed drops back to waiting
        if (any_act || !flags_clear) begin
          s_nxt.fsm = PFSR_ST_HALT;
          s_nxt.cause = s_r.cause | act;
        end else if (i_reload) begin
          s_nxt.fsm = PFSR_ST_RUN;
        end
      end
      default: begin
        s_nxt.fsm = PFSR_ST_HALT;
      end
    endcase

    if (s_nxt.fsm == PFSR_ST_RUN) begin
      s_nxt.cause = '0;
    end
    // Taken from the next state so the outputs go off on the same edge as the fault
    // outputs held off until recovery
    s_nxt.force_off = (s_nxt.fsm != PFSR_ST_RUN);

    // Read data captured in setup so the answer comes from a flop
    if (setup) begin
      s_nxt.pslverr = ~addr_hit;
      s_nxt.prdata = i_apb.pwrite ? 32'h00000000 : {24'h000000, rd_byte};
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      s_r.fsm <= PFSR_ST_RUN;
      s_r.flags <= `PFSR_RST_FLAGS;
      s_r.ctrl <= `PFSR_RST_CTRL;
      s_r.mask <= `PFSR_RST_MASK;
      s_r.mask_locked <= 1'h0;
      s_r.cause <= '0;
      s_r.irq_prev <= '0;
      s_r.irq <= '0;
      s_r.force_off <= 1'h0;
      s_r.prdata <= 32'h00000000;
      s_r.pslverr <= 1'h0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Zero wait states: access phase always completes in one cycle
  always_comb begin
    o_apb.prdata = s_r.prdata;
    o_apb.pready = access;
    o_apb.pslverr = access & s_r.pslverr;
  end

  assign o_force_off = s_r.force_off;
  assign o_irq_req = s_r.irq;

endmodule : pfsr_top

// >>> dv/pfsr_far.sv
// Far-side model: fault pin, comparators, second fault and debug state
`timescale 1ns/100ps

module pfsr_far (
  input wire logic i_clk_sys,
  input wire pfsr_pkg::pfsr_src_t i_want,
  output pfsr_pkg::pfsr_src_t o_src
);
  import pfsr_pkg::*;
  // Sources only move just after an edge, so the pads see clean steps
  always @(posedge i_clk_sys) begin
    o_src <= i_want;
  end
endmodule : pfsr_far

// >>> dv/pfsr_top_assertions.sv
// Port checks for the fault status and recovery block
`timescale 1ns/100ps
`include "pfsr_regs.svh"

module pfsr_chk (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire pfsr_pkg::pfsr_apb_req_t i_apb,
  input wire pfsr_pkg::pfsr_apb_rsp_t o_apb,
  input wire logic i_fault_pin,
  input wire logic i_comp_a,
  input wire logic i_comp_b,
  input wire logic i_second_fault,
  input wire logic i_debug_mode,
  input wire logic [5:0] i_pwm_pins,
  input wire logic o_force_off,
  input wire pfsr_pkg::pfsr_irq_t o_irq_req
);
  import pfsr_pkg::*;
  logic rd_acc;
  logic [3:0] src;
  assign rd_acc = i_apb.psel && i_apb.penable && !i_apb.pwrite;
  assign src = {i_fault_pin, i_comp_a, i_comp_b, i_second_fault};
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_resetn);
  // Two sync flops plus one decision edge put the cause three edges back
  sequence s_rose3(x);
    $past(x, 3) && !$past(x, 4);
  endsequence
  property p_irq(q, x);
    q |-> s_rose3(x) ##1 !q;
  endproperty
  a_irq_pin: assert property (p_irq(o_irq_req.fault_pin, i_fault_pin))
    else $error("pin irq without pin rise");
  a_irq_cmpa: assert property (p_irq(o_irq_req.comp_a, i_comp_a))
    else $error("comp a irq without rise");
  a_irq_cmpb: assert property (p_irq(o_irq_req.comp_b, i_comp_b))
    else $error("comp b irq without rise");
  a_off_cause: assert property ($rose(o_force_off) |->
    $past(i_debug_mode) || $past(src, 3) != 4'h0)
    else $error("outputs forced off without a source");
  a_on_quiet: assert property ($fell(o_force_off) |->
    !$past(i_debug_mode) && $past(src, 3) == 4'h0)
    else $error("outputs resumed with a source active");
  a_rsvd_zero: assert property (rd_acc && i_apb.paddr == `PFSR_ADDR_STAT |->
    o_apb.prdata[31:8] == 24'h0 && o_apb.prdata[6] == 1'b0 && o_apb.prdata[4:3] == 2'h0)
    else $error("reserved status bits not zero");
  a_pin_sample: assert property (rd_acc && i_apb.paddr == `PFSR_ADDR_SAMPLE |->
    o_apb.prdata[6:0] == {$past(i_fault_pin, 3), $past(i_pwm_pins, 3)})
    else $error("sample read does not match pins");
  a_apb_ready: assert property (o_apb.pready == (i_apb.psel && i_apb.penable))
    else $error("ready not given in access phase");
endmodule : pfsr_chk

bind pfsr_top pfsr_chk u_chk (
  .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_apb(i_apb), .o_apb(o_apb),
  .i_fault_pin(i_fault_pin), .i_comp_a(i_comp_a), .i_comp_b(i_comp_b),
  .i_second_fault(i_second_fault), .i_debug_mode(i_debug_mode),
  .i_pwm_pins(i_pwm_pins), .o_force_off(o_force_off), .o_irq_req(o_irq_req)
);

// >>> dv/test_pwm_fault_status_recovery.sv
// Self-checking bench for the fault status and recovery block
`timescale 1ns/100ps
`include "pfsr_regs.svh"

module test_pwm_fault_status_recovery;
  import pfsr_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic rel = 1'b0;
  logic per = 1'b0;
  logic [5:0] pins = 6'h00;
  logic off;
  logic err;
  logic [31:0] rd;
  pfsr_apb_req_t apb = '0;
  pfsr_apb_rsp_t rsp;
  pfsr_src_t want = '0;
  pfsr_src_t src;
  pfsr_irq_t irq;
  int n_errors = 0;
  int n_tests = 0;
  int irq_n [3] = '{0, 0, 0};

  always #25 clk = ~clk;
  always @(posedge clk) begin
    for (int k = 0; k < 3; k++) begin
      if (irq[k] === 1'b1) begin
        irq_n[k]++;
      end
    end
  end

  pfsr_far u_far (.i_clk_sys(clk), .i_want(want), .o_src(src));
  pfsr_top DUT (
    .i_clk_sys(clk), .i_resetn(rst_n), .i_apb(apb), .o_apb(rsp),
    .i_fault_pin(src.fault_pin), .i_comp_a(src.comp_a), .i_comp_b(src.comp_b),
    .i_second_fault(src.second_fault), .i_debug_mode(src.debug), .i_reload(rel),
    .i_period_start(per), .i_pwm_pins(pins), .o_force_off(off), .o_irq_req(irq)
  );

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : test_done

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : check

  task automatic apb_x(input logic [31:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    apb <= '{a, 1'b1, 1'b0, w, d};
    @(posedge clk);
    apb.penable <= 1'b1;
    // No wait-state count is assumed; only the watchdog ends a hang
    do begin
      @(posedge clk);
    end while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    apb.psel <= 1'b0;
    apb.penable <= 1'b0;
  endtask : apb_x

  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    apb_x(a, 1'b1, {24'h0, d});
  endtask : wr

  task automatic st(input logic [7:0] ex);
    apb_x(`PFSR_ADDR_STAT, 1'b0, 32'h0);
    check(rd, {24'h0, ex});
  endtask : st

  task automatic go(input pfsr_src_t s);
    @(posedge clk);
    want <= s;
  endtask : go

  // Bounded wait; an output already at the value is judged at once
  task automatic wait_off(input logic ex);
    for (int k = 0; k < 12 && off !== ex; k++) begin
      @(posedge clk);
    end
    check({31'h0, off}, {31'h0, ex});
  endtask : wait_off

  task automatic pulse(input logic p);
    @(posedge clk);
    rel <= !p;
    per <= p;
    @(posedge clk);
    rel <= 1'b0;
    per <= 1'b0;
  endtask : pulse

  task automatic t_regs;
    apb_x(`PFSR_ADDR_CTRL, 1'b0, 32'h0);
    check(rd, 32'h0);
    wr(`PFSR_ADDR_CTRL, 8'hff);
    apb_x(`PFSR_ADDR_CTRL, 1'b0, 32'h0);
    check(rd, 32'h7f);
    apb_x(32'h0000_0100, 1'b0, 32'h0);
    check({31'h0, err}, 32'h1);
    wr(`PFSR_ADDR_STAT, 8'h58);
    st(8'h00);
    $display("t_regs done");
  endtask : t_regs

  task automatic t_flags;
    pfsr_src_t s [3] = '{5'h10, 5'h08, 5'h02};
    logic [7:0] b [3] = '{8'h01, 8'h02, 8'h04};
    wr(`PFSR_ADDR_CTRL, 8'h00);
    for (int k = 0; k < 3; k++) begin
      go(s[k]);
      wait_off(1'b1);
      wr(`PFSR_ADDR_STAT, 8'hff);
      st(b[k]);
      go('0);
      wait_off(1'b0);
      wr(`PFSR_ADDR_STAT, 8'h00);
      st(b[k]);
      wr(`PFSR_ADDR_STAT, b[k]);
      st(8'h00);
    end
    pulse(1'b0);
    st(8'h80);
    wr(`PFSR_ADDR_STAT, 8'h80);
    st(8'h00);
    $display("t_flags done");
  endtask : t_flags

  task automatic t_debug;
    go(5'h01);
    wait_off(1'b1);
    st(8'h20);
    go('0);
    repeat (6) @(posedge clk);
    wait_off(1'b1);
    pulse(1'b1);
    wait_off(1'b0);
    wr(`PFSR_ADDR_STAT, 8'h20);
    $display("t_debug done");
  endtask : t_debug

  // Each restart select in turn; comparator b rides with the pin so a flag blocks recovery
  task automatic t_soft;
    logic [7:0] c [4] = '{8'h01, 8'h04, 8'h10, 8'h40};
    pfsr_src_t s [4] = '{5'h10, 5'h08, 5'h14, 5'h01};
    for (int k = 0; k < 4; k++) begin
      wr(`PFSR_ADDR_CTRL, c[k]);
      go(s[k]);
      wait_off(1'b1);
      go('0);
      repeat (8) @(posedge clk);
      pulse(1'b0);
      repeat (4) @(posedge clk);
      wait_off(1'b1);
      wr(`PFSR_ADDR_STAT, 8'hff);
      repeat (4) @(posedge clk);
      wait_off(1'b1);
      pulse(1'b0);
      wait_off(1'b0);
      wr(`PFSR_ADDR_STAT, 8'hff);
    end
    $display("t_soft done");
  endtask : t_soft

  task automatic t_irq;
    pfsr_src_t s [3] = '{5'h10, 5'h08, 5'h04};
    logic [7:0] en [3] = '{8'h02, 8'h08, 8'h20};
    int c;
    for (int p = 0; p < 2; p++) begin
      for (int k = 0; k < 3; k++) begin
        wr(`PFSR_ADDR_CTRL, (p == 1) ? en[k] : 8'h00);
        c = irq_n[k];
        go(s[k]);
        wait_off(1'b1);
        go('0);
        wait_off(1'b0);
        check(32'(irq_n[k] - c), 32'(p));
        wr(`PFSR_ADDR_STAT, 8'hff);
      end
    end
    $display("t_irq done");
  endtask : t_irq

  task automatic t_sample;
    logic [5:0] v [2] = '{6'h2a, 6'h15};
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      pins <= v[k];
      repeat (4) @(posedge clk);
      apb_x(`PFSR_ADDR_SAMPLE, 1'b0, 32'h0);
      check(rd, {26'h0, v[k]});
    end
    $display("t_sample done");
  endtask : t_sample

  // Mask is write-once, so this runs last
  task automatic t_mask;
    pfsr_src_t m [4] = '{5'h10, 5'h08, 5'h02, 5'h01};
    wr(`PFSR_ADDR_MASK, 8'h27);
    for (int k = 0; k < 4; k++) begin
      go(m[k]);
      repeat (8) @(posedge clk);
      wait_off(1'b0);
      go('0);
    end
    st(8'h00);
    $display("t_mask done");
  endtask : t_mask

  initial begin
    #400000;
    n_errors++;
    test_done();
  end

  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_flags();
    t_debug();
    t_soft();
    t_irq();
    t_sample();
    t_mask();
    test_done();
  end
endmodule : test_pwm_fault_status_recovery
